// ==== mfr_pkg.sv ====
// Constants, carrier types and states of the flow readout serial slave
//
// Functional notes
// RULE_01 - RTU binary framing, 8N1, 19200 baud default
// RULE_02 - Default address from last two serial digits
// RULE_03 - Reply to reads with function code 03
// RULE_04 - Float sent as bytes 1, 0, 3, 2
// RULE_05 - Integers sent 1,0,3,2 or 1,0 order
// RULE_06 - 8-bit value: pad byte first, data second
// RULE_07 - Address, speed, framing configurable; listed values default
// RULE_08 - Drop bad-check or foreign frames silently
package mfr_pkg;

  // Clock and line rate
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 19200;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_DEFAULT);

  // Silence that closes a request frame, in characters of ten bits
  localparam logic [6:0] GAP_CHARS = 7'h07;
  localparam logic [6:0] BITS_PER_CHAR = 7'h0A;
  localparam logic [6:0] GAP_BITS = 7'(GAP_CHARS * BITS_PER_CHAR);

  // Request layout and protocol codes
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [7:0] BROADCAST = 8'h00;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;

  // Register map, in register numbers
  localparam logic [15:0] REG_FLOW = 16'h0006;
  localparam logic [15:0] REG_TOTAL = 16'h0008;
  localparam logic [15:0] REG_ADDR = 16'h000A;
  localparam logic [16:0] REG_END = 17'h0000B;

  // Check sequence
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // Parity modes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;

  typedef struct packed {
    logic [15:0] bitDiv;
    logic [1:0] parity;
    logic twoStop;
  } mfr_line_cfg_t;

  typedef enum {ST_RX, ST_CHECK, ST_TX} mfr_state_t;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ==== mfr_uart.sv ====
// Character receiver and transmitter of the serial link
`timescale 1ns/1ps
`default_nettype none
module mfr_uart
(
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire mfr_pkg::mfr_line_cfg_t cfg, // Bit period and framing
  input wire logic rxLine, // Receive line, idle high
  output logic rxIdle, // No character in progress
  output logic rxValid, // Character received
  output logic [7:0] rxData, // Received byte
  output logic rxErr, // Stop or parity fault
  input wire logic txGo, // Start a character
  input wire logic [7:0] txByte, // Byte to send
  output logic txBusy, // Character in progress
  output logic txLine // Transmit line
);

  logic [11:0] txSh_r;
  logic [3:0] txLeft_r;
  logic [15:0] txTmr_r;
  logic [9:0] rxSh_r;
  logic [3:0] rxIdx_r;
  logic [15:0] rxTmr_r;
  logic rxOn_r;

  wire parOn = cfg.parity != mfr_pkg::PAR_NONE;
  wire oddPar = cfg.parity == mfr_pkg::PAR_ODD;
  wire txPar = (^txByte) ^ oddPar;
  // Start, eight data, optional parity, one or two stop bits
  wire [11:0] txFrame = parOn ? {2'b11, txPar, txByte, 1'b0} : {3'b111, txByte, 1'b0}; // [RULE_01]
  // One tick per bit plus a closing tick at the end of the last stop bit
  wire [3:0] txTicks = 4'hB + {3'h0, parOn} + {3'h0, cfg.twoStop};
  wire [3:0] rxLast = parOn ? 4'hA : 4'h9;
  wire parBad = parOn && (rxSh_r[9] != ((^rxSh_r[8:1]) ^ oddPar));

  assign txBusy = txLeft_r != 4'h0;
  assign rxIdle = !rxOn_r && rxLine;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      txSh_r <= 12'hFFF;
      txLeft_r <= 4'h0;
      txTmr_r <= 16'h0000;
      txLine <= 1'b1;
    end
    else if (txGo && !txBusy)
    begin
      txSh_r <= txFrame;
      txLeft_r <= txTicks;
      txTmr_r <= 16'h0000;
    end
    else if (txBusy && txTmr_r != 16'h0000)
      txTmr_r <= txTmr_r - 16'h0001;
    else if (txBusy)
    begin
      txLine <= txSh_r[0];
      txSh_r <= {1'b1, txSh_r[11:1]};
      txTmr_r <= cfg.bitDiv - 16'h0001;
      txLeft_r <= txLeft_r - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver, sampling each bit at its middle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rxOn_r <= 1'b0;
      rxIdx_r <= 4'h0;
      rxTmr_r <= 16'h0000;
      rxSh_r <= 10'h000;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxErr <= 1'b0;
    end
    else
    begin
      rxValid <= 1'b0;
      if (!rxOn_r)
      begin
        if (!rxLine)
        begin
          rxOn_r <= 1'b1;
          rxIdx_r <= 4'h0;
          rxTmr_r <= {1'b0, cfg.bitDiv[15:1]};
        end
      end
      else if (rxTmr_r != 16'h0000)
        rxTmr_r <= rxTmr_r - 16'h0001;
      else
      begin
        rxTmr_r <= cfg.bitDiv - 16'h0001;
        rxIdx_r <= rxIdx_r + 4'h1;
        if (rxIdx_r != rxLast)
          rxSh_r[rxIdx_r] <= rxLine;
        // A start bit that is high at its middle was a glitch
        if (rxIdx_r == 4'h0 && rxLine)
          rxOn_r <= 1'b0;
        if (rxIdx_r == rxLast)
        begin
          rxOn_r <= 1'b0;
          rxValid <= 1'b1;
          rxData <= rxSh_r[8:1];
          rxErr <= !rxLine || parBad; // [RULE_01]
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== mfr_modbus_readout.sv ====
// Serial slave that answers holding-register reads of flow and consumption
`timescale 1ns/1ps
`default_nettype none
module mfr_modbus_readout
#(
  parameter logic [15:0] DEFAULT_DIV = mfr_pkg::BAUD_DIV
)
(
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic busIn, // Line receiver output
  output logic busOut, // Line driver input
  output logic busOe, // Line driver enable
  input wire logic [31:0] flowValue, // Flow rate, float bits
  input wire logic [31:0] totalValue, // Consumption, unsigned
  input wire logic [7:0] serialDigits, // Last two serial digits, BCD
  input wire logic [7:0] cfgAddr, // Bus address, zero selects default
  input wire logic [15:0] cfgBaudDiv, // Clocks per bit, zero selects default
  input wire logic [1:0] cfgParity, // Parity mode
  input wire logic cfgTwoStop, // Two stop bits
  output logic replyDone, // Reply finished
  output logic frameDropped // Request discarded
);

  mfr_pkg::mfr_state_t state_r;
  logic [7:0] req_r [0:7];
  logic [3:0] rxCnt_r;
  logic rxBad_r;
  logic [15:0] rxCrc_r;
  logic [23:0] gap_r;
  logic [3:0] txIdx_r;
  logic [15:0] txCrc_r;
  logic [7:0] excCode_r;
  logic [2:0] off_r;
  logic [2:0] qty_r;
  logic [31:0] flowSnap_r;
  logic [31:0] totSnap_r;
  logic [7:0] addrSnap_r;

  mfr_pkg::mfr_line_cfg_t lineCfg;
  logic rxIdle;
  logic rxValid;
  logic [7:0] rxData;
  logic rxErr;
  logic txBusy;
  logic txLine;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration and address
  wire [7:0] serialAddr = ({4'h0, serialDigits[7:4]} * 8'h0A) + {4'h0, serialDigits[3:0]};
  wire [7:0] ownAddr = (cfgAddr != mfr_pkg::BROADCAST) ? cfgAddr : serialAddr; // [RULE_02]
  wire [15:0] bitDiv = (cfgBaudDiv != 16'h0000) ? cfgBaudDiv : DEFAULT_DIV; // [RULE_07]
  assign lineCfg = {bitDiv, cfgParity, cfgTwoStop}; // [RULE_07]
  wire [23:0] gapLimit = {8'h00, bitDiv} * {17'h00000, mfr_pkg::GAP_BITS};

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode
  wire [15:0] reqStart = {req_r[2], req_r[3]};
  wire [15:0] reqQty = {req_r[4], req_r[5]};
  wire [16:0] reqEnd = {1'b0, reqStart} + {1'b0, reqQty};
  wire addrOk = req_r[0] == ownAddr && req_r[0] != mfr_pkg::BROADCAST;
  wire frameOk = rxCnt_r == mfr_pkg::REQ_LEN && !rxBad_r && rxCrc_r == 16'h0000 && addrOk; // [RULE_08]
  wire funcOk = req_r[1] == mfr_pkg::FUNC_READ;
  wire rangeOk = reqQty != 16'h0000 && reqStart >= mfr_pkg::REG_FLOW && reqEnd <= mfr_pkg::REG_END;
  wire [7:0] excNow = !funcOk ? mfr_pkg::EXC_FUNC : (rangeOk ? mfr_pkg::EXC_NONE : mfr_pkg::EXC_ADDR);
  wire gapHit = rxCnt_r != 4'h0 && gap_r >= gapLimit;

  ////////////////////////////////////////////////////////////////////////////////
  // Reply byte selection
  wire isExc = excCode_r != mfr_pkg::EXC_NONE;
  wire [3:0] payLen = isExc ? 4'h3 : 4'h3 + {qty_r, 1'b0};
  wire [3:0] k = txIdx_r - 4'h3;
  wire [2:0] word = off_r + k[3:1];
  // Low register of each pair carries bytes 1,0 and the high one bytes 3,2
  wire [15:0] wordVal = (word == 3'h0) ? flowSnap_r[15:0] : // [RULE_04]
    (word == 3'h1) ? flowSnap_r[31:16] : // [RULE_04]
    (word == 3'h2) ? totSnap_r[15:0] : // [RULE_05]
    (word == 3'h3) ? totSnap_r[31:16] : // [RULE_05]
    {8'h00, addrSnap_r}; // [RULE_06]
  wire [7:0] dataByte = k[0] ? wordVal[7:0] : wordVal[15:8]; // [RULE_05]
  wire [7:0] funcByte = isExc ? (req_r[1] | mfr_pkg::EXC_FLAG) : mfr_pkg::FUNC_READ; // [RULE_03]
  wire [7:0] thirdByte = isExc ? excCode_r : {4'h0, qty_r, 1'b0};
  wire [7:0] payByte = (txIdx_r == 4'h0) ? addrSnap_r :
    (txIdx_r == 4'h1) ? funcByte :
    (txIdx_r == 4'h2) ? thirdByte : dataByte;
  wire [7:0] txByte = (txIdx_r < payLen) ? payByte :
    (txIdx_r == payLen) ? txCrc_r[7:0] : txCrc_r[15:8];
  wire inTx = state_r == mfr_pkg::ST_TX;
  wire txGo = inTx && !txBusy && txIdx_r != payLen + 4'h2;
  wire txDone = inTx && !txBusy && txIdx_r == payLen + 4'h2;
  // Own transmission is not heard back
  wire rxLine = busOe | busIn;

  mfr_uart u_uart
  (
    .mclk(mclk),
    .rst(rst),
    .cfg(lineCfg),
    .rxLine(rxLine),
    .rxIdle(rxIdle),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxErr(rxErr),
    .txGo(txGo),
    .txByte(txByte),
    .txBusy(txBusy),
    .txLine(txLine)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Request buffer
  always_ff @(posedge mclk)
  begin
    if (state_r == mfr_pkg::ST_RX && rxValid && rxCnt_r < mfr_pkg::REQ_LEN)
      req_r[rxCnt_r[2:0]] <= rxData;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= mfr_pkg::ST_RX;
      rxCnt_r <= 4'h0;
      rxBad_r <= 1'b0;
      rxCrc_r <= mfr_pkg::CRC_INIT;
      gap_r <= 24'h000000;
      txIdx_r <= 4'h0;
      txCrc_r <= mfr_pkg::CRC_INIT;
      excCode_r <= mfr_pkg::EXC_NONE;
      off_r <= 3'h0;
      qty_r <= 3'h0;
      flowSnap_r <= 32'h00000000;
      totSnap_r <= 32'h00000000;
      addrSnap_r <= 8'h00;
      busOut <= 1'b1;
      busOe <= 1'b0;
      replyDone <= 1'b0;
      frameDropped <= 1'b0;
    end
    else
    begin
      busOut <= txLine;
      busOe <= inTx;
      replyDone <= txDone;
      frameDropped <= state_r == mfr_pkg::ST_CHECK && !frameOk; // [RULE_08]
      unique case (state_r)
        mfr_pkg::ST_RX:
        begin
          gap_r <= (!rxIdle || rxCnt_r == 4'h0) ? 24'h000000 : gap_r + 24'h000001;
          if (rxValid)
          begin
            if (rxCnt_r != 4'hF)
              rxCnt_r <= rxCnt_r + 4'h1;
            rxBad_r <= rxBad_r | rxErr;
            rxCrc_r <= mfr_pkg::crc_step(rxCrc_r, rxData);
          end
          if (gapHit)
            state_r <= mfr_pkg::ST_CHECK;
        end
        mfr_pkg::ST_CHECK:
        begin
          rxCnt_r <= 4'h0;
          rxBad_r <= 1'b0;
          rxCrc_r <= mfr_pkg::CRC_INIT;
          gap_r <= 24'h000000;
          txIdx_r <= 4'h0;
          txCrc_r <= mfr_pkg::CRC_INIT;
          excCode_r <= excNow;
          off_r <= 3'(reqStart - mfr_pkg::REG_FLOW);
          qty_r <= reqQty[2:0];
          flowSnap_r <= flowValue;
          totSnap_r <= totalValue;
          addrSnap_r <= ownAddr;
          state_r <= frameOk ? mfr_pkg::ST_TX : mfr_pkg::ST_RX; // [RULE_08]
        end
        mfr_pkg::ST_TX:
        begin
          if (txGo)
          begin
            txIdx_r <= txIdx_r + 4'h1;
            if (txIdx_r < payLen)
              txCrc_r <= mfr_pkg::crc_step(txCrc_r, payByte); // [RULE_03]
          end
          if (txDone)
            state_r <= mfr_pkg::ST_RX;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_default_baud;
    @(posedge mclk) disable iff (rst)
    (cfgBaudDiv == 16'h0000) |-> (lineCfg.bitDiv == DEFAULT_DIV && gapLimit == DEFAULT_DIV * 70);
  endproperty
  a_default_baud: assert property (p_default_baud) else $error("default bit period wrong"); // [RULE_01]

  property p_addr_only;
    @(posedge mclk) disable iff (rst)
    $rose(busOe) |-> (req_r[0] == addrSnap_r && addrSnap_r != 8'h00);
  endproperty
  a_addr_only: assert property (p_addr_only) else $error("reply to foreign address"); // [RULE_02]

  property p_func_byte;
    @(posedge mclk) disable iff (rst)
    (txGo && txIdx_r == 4'h1 && !isExc) |-> (txByte == 8'h03 && req_r[1] == 8'h03);
  endproperty
  a_func_byte: assert property (p_func_byte) else $error("function byte wrong"); // [RULE_03]

  property p_crc_tail;
    @(posedge mclk) disable iff (rst)
    (txGo && txIdx_r == payLen + 4'h1) |-> (txByte == txCrc_r[15:8]) ##1 !txGo[*2];
  endproperty
  a_crc_tail: assert property (p_crc_tail) else $error("check sequence tail wrong"); // [RULE_03]

  property p_float_order;
    @(posedge mclk) disable iff (rst)
    (txGo && !isExc && off_r == 3'h0 && txIdx_r == 4'h3) |-> txByte == flowSnap_r[15:8];
  endproperty
  a_float_order: assert property (p_float_order) else $error("float byte order wrong"); // [RULE_04]

  property p_int_order;
    @(posedge mclk) disable iff (rst)
    (txGo && !isExc && off_r == 3'h2 && txIdx_r == 4'h5) |-> txByte == totSnap_r[31:24];
  endproperty
  a_int_order: assert property (p_int_order) else $error("integer byte order wrong"); // [RULE_05]

  property p_byte_pad;
    @(posedge mclk) disable iff (rst)
    (txGo && !isExc && off_r == 3'h4 && txIdx_r == 4'h3) |-> txByte == 8'h00;
  endproperty
  a_byte_pad: assert property (p_byte_pad) else $error("pad byte not zero"); // [RULE_06]

  property p_cfg_addr;
    @(posedge mclk) disable iff (rst)
    (state_r == mfr_pkg::ST_CHECK && frameOk && cfgAddr != 8'h00) |=> req_r[0] == $past(cfgAddr);
  endproperty
  a_cfg_addr: assert property (p_cfg_addr) else $error("configured address ignored"); // [RULE_07]

  property p_drop_bad;
    @(posedge mclk) disable iff (rst)
    (state_r == mfr_pkg::ST_CHECK && (rxCrc_r != 16'h0000 || !addrOk)) |=> !busOe[*3];
  endproperty
  a_drop_bad: assert property (p_drop_bad) else $error("bad frame answered"); // [RULE_08]

endmodule
`default_nettype wire

// ==== mfr_bus_master.sv ====
// Serial bus master model that polls the flow readout slave
`timescale 1ns/1ps
`default_nettype none
module mfr_bus_master
(
  input wire logic mclk, // System clock
  input wire logic line, // Resolved bus level
  input wire logic [15:0] div, // Clocks per bit
  input wire logic [1:0] par, // Parity mode
  output logic txLine, // Master drive level, idle high
  output logic rxStrobe, // Reply byte received
  output logic [8:0] rxByte // Fault flag and byte
);
  logic sending;
  logic [7:0] b;
  logic bad;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ mfr_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic parBit(input logic [7:0] d);
    return (par == mfr_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction
  task automatic putBit(input logic v);
    txLine = v;
    repeat (div) @(negedge mclk);
  endtask
  // Start, eight data bits LSB first, optional parity, one stop
  task automatic putByte(input logic [7:0] d);
    putBit(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      putBit(d[i]);
    end
    if (par != mfr_pkg::PAR_NONE)
    begin
      putBit(parBit(d));
    end
    putBit(1'b1);
  endtask
  task automatic sendReq(input logic [7:0] a, f, input logic [15:0] s, q, input logic badCrc);
    logic [7:0] m [8];
    logic [15:0] c;
    m = '{a, f, s[15:8], s[7:0], q[15:8], q[7:0], 8'h00, 8'h00};
    c = mfr_pkg::CRC_INIT;
    for (int i = 0; i < 6; i++)
    begin
      c = crc16(c, m[i]);
    end
    c[0] = c[0] ^ badCrc;
    m[6] = c[7:0];
    m[7] = c[15:8];
    sending = 1'b1;
    @(negedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      putByte(m[i]);
    end
    sending = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Receiver samples mid-bit and flags parity or stop faults
  initial
  begin
    txLine = 1'b1;
    rxStrobe = 1'b0;
    rxByte = 9'h000;
    sending = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (!sending && line === 1'b0)
      begin
        repeat (div / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (div) @(posedge mclk);
          b[i] = line;
        end
        bad = 1'b0;
        if (par != mfr_pkg::PAR_NONE)
        begin
          repeat (div) @(posedge mclk);
          bad = (line !== parBit(b));
        end
        repeat (div) @(posedge mclk);
        bad = bad | (line !== 1'b1);
        rxByte <= {bad, b};
        rxStrobe <= 1'b1;
        @(posedge mclk);
        rxStrobe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== mfr_modbus_readout_test.sv ====
// Self-checking bench for the flow readout serial slave
`timescale 1ns/1ps
`default_nettype none
module mfr_modbus_readout_test;
  logic mclk, rst, busIn, busOut, busOe, replyDone, frameDropped;
  logic [31:0] flowValue, totalValue;
  logic [7:0] serialDigits, cfgAddr, myAddr;
  logic [15:0] cfgBaudDiv, crc;
  logic [1:0] cfgParity;
  logic cfgTwoStop, mTx, mStrobe;
  logic [8:0] mByte;
  logic [8:0] expQ [$];
  int num_errors = 0;
  int n_tests = 0;
  int seed = 32'h26C3327E;
  // Short default bit period for the slave, so the default path can be run
  localparam logic [15:0] BENCH_DIV = 16'h000C;
  logic [15:0] mDiv;
  assign mDiv = (cfgBaudDiv != 16'h0000) ? cfgBaudDiv : BENCH_DIV;
  // Slave drives the pair while enabled, otherwise the master does
  assign busIn = busOe ? busOut : mTx;
  mfr_modbus_readout #(.DEFAULT_DIV(BENCH_DIV)) u_dut (.mclk(mclk), .rst(rst),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .flowValue(flowValue),
    .totalValue(totalValue),
    .serialDigits(serialDigits), .cfgAddr(cfgAddr), .cfgBaudDiv(cfgBaudDiv),
    .cfgParity(cfgParity), .cfgTwoStop(cfgTwoStop), .replyDone(replyDone),
    .frameDropped(frameDropped));
  mfr_bus_master u_master (.mclk(mclk), .line(busIn), .div(mDiv), .par(cfgParity),
    .txLine(mTx), .rxStrobe(mStrobe), .rxByte(mByte));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reply bytes, end of reply and drop events against the oldest note
  always @(posedge mclk)
  begin
    if (mStrobe === 1'b1 || replyDone === 1'b1 || frameDropped === 1'b1)
      check(mStrobe ? mByte : (replyDone ? 9'h100 : 9'h1FF),
        expQ.size() > 0 ? expQ.pop_front() : 9'h1EE);
  end
  task automatic note(input logic [7:0] d);
    expQ.push_back({1'b0, d});
    crc = u_master.crc16(crc, d);
  endtask
  task automatic noteEnd();
    expQ.push_back({1'b0, crc[7:0]});
    expQ.push_back({1'b0, crc[15:8]});
    expQ.push_back(9'h100);
  endtask
  task automatic req(input logic [7:0] a, f, input logic [15:0] s, q, input logic bad);
    int n;
    u_master.sendReq(a, f, s, q, bad);
    for (n = 0; n < 6000 && replyDone !== 1'b1 && frameDropped !== 1'b1; n++)
      @(posedge mclk);
    repeat (4) @(negedge mclk);
  endtask
  task automatic readRegs(input logic [15:0] s, q);
    logic [15:0] r [5];
    r = '{flowValue[15:0], flowValue[31:16], totalValue[15:0], totalValue[31:16],
      {8'h00, myAddr}};
    crc = mfr_pkg::CRC_INIT;
    note(myAddr);
    note(mfr_pkg::FUNC_READ);
    note(8'(2 * q));
    for (int i = 0; i < q; i++)
    begin
      note(r[s - 6 + i][15:8]);
      note(r[s - 6 + i][7:0]);
    end
    noteEnd();
    req(myAddr, mfr_pkg::FUNC_READ, s, q, 1'b0);
  endtask
  task automatic badReq(input logic [7:0] f, input logic [15:0] s, q, input logic [7:0] code);
    crc = mfr_pkg::CRC_INIT;
    note(myAddr);
    note(f | mfr_pkg::EXC_FLAG);
    note(code);
    noteEnd();
    req(myAddr, f, s, q, 1'b0);
  endtask
  task automatic dropReq(input logic [7:0] a, input logic bad);
    expQ.push_back(9'h1FF);
    req(a, mfr_pkg::FUNC_READ, 16'h0006, 16'h0002, bad);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (80000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
  initial
  begin
    rst = 1'b1;
    flowValue = 32'h0;
    totalValue = 32'h0;
    serialDigits = 8'h37;
    cfgAddr = 8'h00;
    cfgBaudDiv = 16'h0008;
    cfgParity = mfr_pkg::PAR_NONE;
    cfgTwoStop = 1'b0;
    myAddr = 8'h25; // Serial digits 37
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    for (int k = 0; k < 2; k++)
    begin
      flowValue = $random(seed);
      totalValue = $random(seed);
      readRegs(16'h0006, 16'h0005);
      readRegs(16'h0008, 16'h0002);
    end
    readRegs(16'h000A, 16'h0001);
    badReq(8'h04, 16'h0006, 16'h0002, mfr_pkg::EXC_FUNC);
    badReq(8'h01, 16'h0006, 16'h0001, mfr_pkg::EXC_FUNC);
    badReq(8'h03, 16'h0006, 16'h0000, mfr_pkg::EXC_ADDR);
    badReq(8'h03, 16'h000B, 16'h0001, mfr_pkg::EXC_ADDR);
    badReq(8'h03, 16'h0006, 16'h0006, mfr_pkg::EXC_ADDR);
    badReq(8'h03, 16'h0005, 16'h0001, mfr_pkg::EXC_ADDR);
    dropReq(8'h26, 1'b0);
    dropReq(myAddr, 1'b1);
    dropReq(mfr_pkg::BROADCAST, 1'b0);
    for (int p = 1; p < 3; p++)
    begin
      cfgAddr = 8'h5A;
      cfgBaudDiv = 16'h000A;
      cfgParity = 2'(p);
      cfgTwoStop = p[0];
      flowValue = $random(seed);
      dropReq(8'h25, 1'b0);
      myAddr = 8'h5A;
      readRegs(16'h0006, 16'h0005);
    end
    cfgBaudDiv = 16'h0000;
    cfgParity = mfr_pkg::PAR_NONE;
    cfgTwoStop = 1'b0;
    totalValue = $random(seed);
    readRegs(16'h0008, 16'h0002);
    check(9'(expQ.size()), 9'h000);
    end_sim();
  end
endmodule
`default_nettype wire
